/* inc/token_net_pkg.sv */
/*
 Package for the status, mask and diagnostic register bank of a token-passing node.
 Holds offsets, bit positions, reset values and command codes.
 Assumes the surrounding host bus decodes word addresses A[5:1].
*/
package token_net_pkg;
    localparam logic [5:0] OFF_STATUS = 6'h00;
    localparam logic [5:0] OFF_DIAG = 6'h02;

    localparam int BIT_TX_IDLE = 0;
    localparam int BIT_TX_ACKED = 1;
    localparam int BIT_RING_REBUILD = 2;
    localparam int BIT_POWER_ON = 4;

    localparam int BIT_SUCC_LOST = 1;
    localparam int BIT_PROBE_MATCH = 2;
    localparam int BIT_NAK_OVER = 3;
    localparam int BIT_TOKEN_SEEN = 4;
    localparam int BIT_RX_ACT = 5;
    localparam int BIT_CLASH_ID = 6;
    localparam int BIT_LOCAL_TMO = 7;

    localparam int MASK_NAK = 3;
    localparam int MASK_REBUILD = 2;
    localparam int MASK_SUCC = 1;
    localparam int MASK_IDLE = 0;

    // Status bits 7..5 read as ones
    localparam logic [15:0] STATUS_FIXED = 16'h00E0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    localparam logic [7:0] CMD_SEND_CANCEL = 8'h01;
    localparam logic [7:0] CMD_SEND = 8'h03;
    localparam logic [7:0] CMD_SUCC_CLEAR = 8'h09;
    localparam logic [7:0] CMD_POR_NAK_CLEAR = 8'h0E;
    localparam logic [7:0] CMD_REBUILD_CLEAR = 8'h16;

    localparam logic [7:0] NAK_LIMIT_SHORT = 8'h04;
    localparam logic [7:0] NAK_LIMIT_LONG = 8'h80;
endpackage

/* rtl/nak_counter.sv */
/*
 Counts refusals of free-buffer enquiries and pulses on reaching 4 or 128.
 Assumes refusal strobes come from the protocol engine and restart from the host send command, both on mclk_in.
*/
`timescale 1ns/100ps
module nak_counter (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic soft_rst_in,
    input wire logic long_limit_in,
    input wire logic nak_in,
    input wire logic restart_in,
    output logic overrun_out
);
    typedef struct packed {
        logic [7:0] count;
        logic hit;
    } state_s;

    state_s cur;
    state_s next_cur;
    logic [7:0] limit;

    always_comb begin
        limit = long_limit_in ? token_net_pkg::NAK_LIMIT_LONG : token_net_pkg::NAK_LIMIT_SHORT;
        next_cur = cur;
        next_cur.hit = 1'b0;
        if (soft_rst_in || restart_in) begin
            next_cur.count = 8'h00;
        end else if (nak_in) begin
            if (cur.count + 8'h01 >= limit) begin
                next_cur.hit = 1'b1;
                next_cur.count = 8'h00;
            end else begin
                next_cur.count = cur.count + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign overrun_out = cur.hit;
endmodule

/* rtl/sticky_flag.sv */
/*
 One sticky event flag: set wins over clear.
 Assumes set and clear come from logic on mclk_in.
*/
`timescale 1ns/100ps
module sticky_flag (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic init_in,
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag_out
);
    typedef struct packed {
        logic flag;
    } state_s;

    state_s cur;
    state_s next_cur;

    always_comb begin
        next_cur = cur;
        if (set_in) begin
            next_cur.flag = 1'b1;
        end else if (clear_in) begin
            next_cur.flag = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cur.flag <= init_in;
        end else begin
            cur <= next_cur;
        end
    end

    assign flag_out = cur.flag;
endmodule

/* rtl/token_net_status_diag_regs.sv */
/*
 Status, event mask and diagnostic register bank of a token-passing node, with the
 transmit-idle tracker and communication interrupt.
 Assumes a synchronous host bus on mclk_in with one-cycle read and write strobes, and
 event strobes from the protocol engine on the same clock.
 // Function
 // - Power-on flag sets on any reset and clears only by command 0Eh.
 // - Ring-rebuild flag sets on reconfiguration, clears on soft reset or command 16h.
 // - Transmit-acked sets on good non-broadcast send, clears on soft reset or send 03h.
 // - Transmit-idle is 1 when sending is done and drops on a send command.
 // - In free-buffer or single-packet mode idle returns on packet end or cancel 01h.
 // - In automatic resend idle stays 0 until cancel or single-packet becomes 1.
 // - Soft reset sets transmit-idle, also shown in the extended status bit 0.
 // - Soft reset clears the write-only event mask.
 // - Masked NAK, rebuild, successor-lost or idle raise the interrupt with core enable.
 // - Local-rebuild-timeout sets on own timer expiry, clears on read or soft reset.
 // - Clashing-ID sets offline on ID clash or online on own token, clears on read.
 // - Receive-activity sets on receive activity, clears on read or soft reset.
 // - Token-seen sets on a foreign token, clears on read or soft reset.
 // - NAK-overrun sets after 4 or 128 refusals, cleared by soft reset or 0Eh only.
 // - Probe-ID-match sets on a foreign token matching the probe ID, clears on read.
 // - Successor-lost sets when the successor ignores the token, clears by 09h.
*/
`timescale 1ns/100ps
module token_net_status_diag_regs (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic soft_rst_in,
    input wire logic [5:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out,
    input wire logic tx_buffer_mode,
    input wire logic single_packet_send,
    input wire logic online_enable,
    input wire logic nak_long_limit_in,
    input wire logic core_irq_enable_in,
    input wire logic reconfig_in,
    input wire logic local_timeout_in,
    input wire logic tx_done_in,
    input wire logic tx_ok_unicast_in,
    input wire logic id_clash_in,
    input wire logic own_token_in,
    input wire logic rx_activity_in,
    input wire logic foreign_token_in,
    input wire logic [7:0] foreign_token_id_in,
    input wire logic [7:0] probe_id_in,
    input wire logic nak_in,
    input wire logic succ_lost_in,
    output logic tx_idle_flag_out,
    output logic tx_active_out,
    output logic comm_irq_out
);
    typedef struct packed {
        logic [3:0] mask;
        logic tx_idle;
        logic auto_send;
        logic [15:0] rdata;
    } state_s;

    state_s cur;
    state_s next_cur;

    logic wr_status;
    logic wr_cmd;
    logic rd_status;
    logic rd_diag;
    logic cmd_send;
    logic cmd_cancel;
    logic nak_hit;
    logic any_rst;
    logic power_on_flag;
    logic ring_rebuild_flag;
    logic tx_acked_flag;
    logic local_rebuild_timeout;
    logic clashing_id_flag;
    logic rx_activity_flag;
    logic token_seen_flag;
    logic nak_overrun_flag;
    logic probe_id_match;
    logic successor_lost_flag;
    logic [15:0] status_word;
    logic [15:0] diag_word;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a[5:1] == off[5:1]);
    endfunction

    // Reads and writes decode apart
    assign rd_status = rd_in && hit(addr_in, token_net_pkg::OFF_STATUS);
    assign rd_diag = rd_in && hit(addr_in, token_net_pkg::OFF_DIAG);
    assign wr_status = wr_in && hit(addr_in, token_net_pkg::OFF_STATUS);
    assign wr_cmd = wr_in && hit(addr_in, token_net_pkg::OFF_DIAG);
    assign cmd_send = wr_cmd && (wdata_in[7:0] == token_net_pkg::CMD_SEND);
    assign cmd_cancel = wr_cmd && (wdata_in[7:0] == token_net_pkg::CMD_SEND_CANCEL);
    assign any_rst = rst_in || soft_rst_in;

    nak_counter u_nak (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .soft_rst_in(soft_rst_in),
        .long_limit_in(nak_long_limit_in),
        .nak_in(nak_in),
        .restart_in(cmd_send),
        .overrun_out(nak_hit)
    );

    // Power-on flag: reset sets it, 0Eh clears it
    sticky_flag u_por (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b1),
        .set_in(1'b0),
        .clear_in(wr_cmd && wdata_in[7:0] == token_net_pkg::CMD_POR_NAK_CLEAR),
        .flag_out(power_on_flag)
    );
    sticky_flag u_rebuild (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(reconfig_in),
        .clear_in(wr_cmd && wdata_in[7:0] == token_net_pkg::CMD_REBUILD_CLEAR),
        .flag_out(ring_rebuild_flag)
    );
    sticky_flag u_acked (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(tx_ok_unicast_in),
        .clear_in(cmd_send),
        .flag_out(tx_acked_flag)
    );
    sticky_flag u_local_tmo (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(local_timeout_in),
        .clear_in(rd_diag),
        .flag_out(local_rebuild_timeout)
    );
    sticky_flag u_clash (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(online_enable ? own_token_in : id_clash_in),
        .clear_in(rd_diag),
        .flag_out(clashing_id_flag)
    );
    sticky_flag u_rx_act (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(rx_activity_in),
        .clear_in(rd_diag),
        .flag_out(rx_activity_flag)
    );
    sticky_flag u_token (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(foreign_token_in),
        .clear_in(rd_diag),
        .flag_out(token_seen_flag)
    );
    sticky_flag u_nak_flag (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(nak_hit),
        .clear_in(wr_cmd && wdata_in[7:0] == token_net_pkg::CMD_POR_NAK_CLEAR),
        .flag_out(nak_overrun_flag)
    );
    sticky_flag u_probe (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(foreign_token_in && foreign_token_id_in == probe_id_in),
        .clear_in(rd_diag),
        .flag_out(probe_id_match)
    );
    sticky_flag u_succ (
        .mclk_in(mclk_in), .rst_in(any_rst), .init_in(1'b0),
        .set_in(succ_lost_in),
        .clear_in(wr_cmd && wdata_in[7:0] == token_net_pkg::CMD_SUCC_CLEAR),
        .flag_out(successor_lost_flag)
    );

    always_comb begin
        status_word = token_net_pkg::STATUS_FIXED;
        status_word[token_net_pkg::BIT_POWER_ON] = power_on_flag;
        status_word[token_net_pkg::BIT_RING_REBUILD] = ring_rebuild_flag;
        status_word[token_net_pkg::BIT_TX_ACKED] = tx_acked_flag;
        status_word[token_net_pkg::BIT_TX_IDLE] = cur.tx_idle;
        diag_word = 16'h0000;
        diag_word[token_net_pkg::BIT_LOCAL_TMO] = local_rebuild_timeout;
        diag_word[token_net_pkg::BIT_CLASH_ID] = clashing_id_flag;
        diag_word[token_net_pkg::BIT_RX_ACT] = rx_activity_flag;
        diag_word[token_net_pkg::BIT_TOKEN_SEEN] = token_seen_flag;
        diag_word[token_net_pkg::BIT_NAK_OVER] = nak_overrun_flag;
        diag_word[token_net_pkg::BIT_PROBE_MATCH] = probe_id_match;
        diag_word[token_net_pkg::BIT_SUCC_LOST] = successor_lost_flag;
    end

    always_comb begin
        next_cur = cur;
        if (wr_status) begin
            next_cur.mask = wdata_in[3:0];
        end
        // Transmit-idle tracker
        if (cmd_send) begin
            next_cur.tx_idle = 1'b0;
            next_cur.auto_send = tx_buffer_mode && !single_packet_send;
        end else if (cmd_cancel) begin
            next_cur.tx_idle = 1'b1;
            next_cur.auto_send = 1'b0;
        end else if (cur.auto_send) begin
            if (single_packet_send) begin
                next_cur.tx_idle = 1'b1;
                next_cur.auto_send = 1'b0;
            end
        end else if (tx_done_in && !cur.tx_idle) begin
            next_cur.tx_idle = 1'b1;
        end
        if (rd_status) begin
            next_cur.rdata = status_word;
        end else if (rd_diag) begin
            next_cur.rdata = diag_word;
        end else if (rd_in) begin
            next_cur.rdata = 16'h0000;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in || soft_rst_in) begin
            cur.mask <= token_net_pkg::MASK_RESET;
            cur.tx_idle <= 1'b1;
            cur.auto_send <= 1'b0;
            cur.rdata <= 16'h0000;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata_out = cur.rdata;
    assign tx_idle_flag_out = cur.tx_idle;
    assign tx_active_out = !cur.tx_idle;
    assign comm_irq_out = core_irq_enable_in && (
        (cur.mask[token_net_pkg::MASK_NAK] && nak_overrun_flag) ||
        (cur.mask[token_net_pkg::MASK_REBUILD] && ring_rebuild_flag) ||
        (cur.mask[token_net_pkg::MASK_SUCC] && successor_lost_flag) ||
        (cur.mask[token_net_pkg::MASK_IDLE] && cur.tx_idle));
endmodule

/* test/token_net_host_model.sv */
/* Host model: word reads and writes on the register bank.
   Assumes the bank shares mclk_in; drives at falling edges. */
`timescale 1ns/100ps
module token_net_host_model (
    input wire logic mclk_in,
    input wire logic [15:0] rdata_in,
    output logic [5:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [15:0] wdata_out
);
    initial begin
        addr_out = 6'h00;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 16'h0000;
    end
    task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
        @(negedge mclk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge mclk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask
    task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
        @(negedge mclk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge mclk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule

/* test/token_net_status_diag_regs_asserts.sv */
/* Checker for the status, mask and diagnostic bank, seen at its ports.
   Assumes one clock; hardware reset disables, soft reset is watched. */
`timescale 1ns/100ps
module token_net_status_diag_regs_asserts (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic soft_rst_in,
    input wire logic [5:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [15:0] rdata_out,
    input wire logic tx_buffer_mode,
    input wire logic single_packet_send,
    input wire logic core_irq_enable_in,
    input wire logic tx_done_in,
    input wire logic tx_idle_flag_out,
    input wire logic tx_active_out,
    input wire logic comm_irq_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    wire cmd_wr = wr_in && addr_in[5:1] == 5'h01;
    wire rd_stat = rd_in && addr_in[5:1] == 5'h00;
    wire rd_diag = rd_in && addr_in[5:1] == 5'h01;
    AST_ACTIVE_INV: assert property (tx_active_out == !tx_idle_flag_out)
        else $error("active is not the inverse of idle");
    AST_SEND_BUSY: assert property (cmd_wr && wdata_in[7:0] == 8'h03 && !soft_rst_in
        |=> !tx_idle_flag_out) else $error("send did not drop idle");
    AST_CANCEL_IDLE: assert property (cmd_wr && wdata_in[7:0] == 8'h01
        |=> tx_idle_flag_out) else $error("cancel did not raise idle");
    AST_AUTO_HOLD: assert property (!tx_idle_flag_out && tx_buffer_mode
        && !single_packet_send && !wr_in && !soft_rst_in |=> !tx_idle_flag_out)
        else $error("auto resend left busy state");
    AST_SINGLE_DONE: assert property (!tx_idle_flag_out && !tx_buffer_mode
        && tx_done_in && !wr_in |=> tx_idle_flag_out) else $error("packet end kept busy");
    AST_IRQ_GATE: assert property (!core_irq_enable_in |-> !comm_irq_out)
        else $error("interrupt without core enable");
    AST_UNMAPPED: assert property (rd_in && addr_in[5:2] != 4'h0
        |=> rdata_out == 16'h0000) else $error("unmapped read not zero");
    AST_STATUS_READ: assert property (rd_stat && !soft_rst_in
        |=> rdata_out[0] == $past(tx_idle_flag_out) && rdata_out[15:5] == 11'h007)
        else $error("status read mismatch");
    AST_DIAG_READ: assert property (rd_diag && !soft_rst_in
        |=> rdata_out[15:8] == 8'h00 && !rdata_out[0]) else $error("diag reserved bits set");
    AST_RDATA_HOLD: assert property (!rd_in && !soft_rst_in |=> $stable(rdata_out))
        else $error("read data changed without read");
    AST_SOFT_RST: assert property (soft_rst_in |=> tx_idle_flag_out && !comm_irq_out)
        else $error("soft reset left busy or interrupt");
    cover property (cmd_wr && wdata_in[7:0] == 8'h03);
    cover property ($rose(comm_irq_out));
    cover property (rd_diag ##1 rdata_out != 16'h0000);
endmodule
bind token_net_status_diag_regs token_net_status_diag_regs_asserts i_chk (.mclk_in, .rst_in,
    .soft_rst_in, .addr_in, .rd_in, .wr_in, .wdata_in, .rdata_out, .tx_buffer_mode,
    .single_packet_send, .core_irq_enable_in, .tx_done_in, .tx_idle_flag_out,
    .tx_active_out, .comm_irq_out);

/* test/token_net_status_diag_regs_tb_top.sv */
/* Testbench for the status, mask and diagnostic bank.
   Assumes the host model for bus cycles and pulses events itself. */
`timescale 1ns/100ps
module token_net_status_diag_regs_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic soft_rst = 1'b0;
    logic mode = 1'b0;
    logic single = 1'b0;
    logic online = 1'b0;
    logic long_lim = 1'b0;
    logic core_en = 1'b1;
    logic [9:0] ev = 10'h000;
    logic [7:0] fid = 8'h00;
    logic [7:0] pid = 8'h05;
    logic [5:0] addr;
    logic rd, wr, idle, active, irq;
    logic [15:0] wdata, rdata;
    int failures = 0;
    int comparisons = 0;
    always #4 mclk = ~mclk;
    token_net_host_model i_host (.mclk_in(mclk), .rdata_in(rdata), .addr_out(addr),
        .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
    token_net_status_diag_regs i_dut (.mclk_in(mclk), .rst_in(rst), .soft_rst_in(soft_rst),
        .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata),
        .tx_buffer_mode(mode), .single_packet_send(single), .online_enable(online),
        .nak_long_limit_in(long_lim), .core_irq_enable_in(core_en), .reconfig_in(ev[0]),
        .local_timeout_in(ev[1]), .tx_done_in(ev[2]), .tx_ok_unicast_in(ev[3]),
        .id_clash_in(ev[4]), .own_token_in(ev[5]), .rx_activity_in(ev[6]),
        .foreign_token_in(ev[7]), .foreign_token_id_in(fid), .probe_id_in(pid),
        .nak_in(ev[8]), .succ_lost_in(ev[9]), .tx_idle_flag_out(idle),
        .tx_active_out(active), .comm_irq_out(irq));
    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expect_rd(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_host.read_reg(a, d);
        check(d, exp);
    endtask
    task automatic flag(input logic b, input logic e);
        check({15'h0000, b}, {15'h0000, e});
    endtask
    task automatic fire(input int i);
        @(negedge mclk);
        ev[i] = 1'b1;
        @(negedge mclk);
        ev = 10'h000;
    endtask
    task automatic cmd(input logic [15:0] c);
        i_host.write_reg(6'h02, c);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        finish_test();
    end
    initial begin
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        expect_rd(6'h00, 16'h00F1);
        expect_rd(6'h02, 16'h0000);
        expect_rd(6'h04, 16'h0000);
        i_host.write_reg(6'h00, 16'h000F);
        expect_rd(6'h00, 16'h00F1);
        flag(irq, 1'b1);
        core_en = 1'b0;
        @(negedge mclk);
        flag(irq, 1'b0);
        core_en = 1'b1;
        cmd(16'h000E);
        expect_rd(6'h00, 16'h00E1);
        flag(active, 1'b0);
        cmd(16'h0003);
        flag(idle, 1'b0);
        flag(active, 1'b1);
        flag(irq, 1'b0);
        fire(3);
        fire(2);
        expect_rd(6'h00, 16'h00E3);
        cmd(16'h0003);
        expect_rd(6'h00, 16'h00E0);
        cmd(16'h0001);
        expect_rd(6'h00, 16'h00E1);
        mode = 1'b1;
        cmd(16'h0003);
        fire(2);
        flag(idle, 1'b0);
        cmd(16'h0001);
        flag(idle, 1'b1);
        cmd(16'h0003);
        single = 1'b1;
        @(negedge mclk);
        flag(idle, 1'b1);
        single = 1'b0;
        mode = 1'b0;
        fid = 8'h05;
        fire(4);
        fire(6);
        fire(1);
        fire(7);
        expect_rd(6'h02, 16'h00F4);
        expect_rd(6'h02, 16'h0000);
        online = 1'b1;
        fire(5);
        fid = 8'h06;
        fire(7);
        expect_rd(6'h02, 16'h0050);
        fire(0);
        expect_rd(6'h00, 16'h00E5);
        i_host.write_reg(6'h00, 16'h0004);
        flag(irq, 1'b1);
        cmd(16'h0016);
        expect_rd(6'h00, 16'h00E1);
        flag(irq, 1'b0);
        repeat (3) fire(8);
        expect_rd(6'h02, 16'h0000);
        fire(8);
        expect_rd(6'h02, 16'h0008);
        fire(9);
        expect_rd(6'h02, 16'h000A);
        expect_rd(6'h02, 16'h000A);
        cmd(16'h0009);
        expect_rd(6'h02, 16'h0008);
        cmd(16'h000E);
        expect_rd(6'h02, 16'h0000);
        long_lim = 1'b1;
        cmd(16'h0003);
        cmd(16'h0001);
        repeat (127) fire(8);
        expect_rd(6'h02, 16'h0000);
        fire(8);
        i_host.write_reg(6'h00, 16'h0008);
        flag(irq, 1'b1);
        expect_rd(6'h02, 16'h0008);
        i_host.write_reg(6'h00, 16'h000F);
        fire(0);
        @(negedge mclk);
        soft_rst = 1'b1;
        @(negedge mclk);
        soft_rst = 1'b0;
        flag(irq, 1'b0);
        expect_rd(6'h00, 16'h00F1);
        expect_rd(6'h02, 16'h0000);
        finish_test();
    end
endmodule
